// file: mbwd_pkg.sv
// Shared constants and types of the Modbus write and diagnosis handler.
// Assumes a byte-wide request stream whose last byte is flagged by the framing layer.
package mbwd_pkg;

  localparam logic [7:0] MBWD_FC_DIAG = 8'h08;
  localparam logic [7:0] MBWD_FC_WR_SAVE = 8'h06;
  localparam logic [7:0] MBWD_FC_WR_RAM = 8'h41;
  localparam logic [7:0] MBWD_FC_WRM_RAM = 8'h42;
  localparam logic [7:0] MBWD_EXC_FLAG = 8'h80;

  localparam logic [7:0] MBWD_EXC_NONE = 8'h00;
  localparam logic [7:0] MBWD_EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] MBWD_EXC_ILL_VALUE = 8'h03;

  localparam logic [15:0] MBWD_SUB_ECHO = 16'h0000;
  localparam logic [15:0] MBWD_SUB_CLR_CNT = 16'h000a;

  localparam int MBWD_MAX_REGS = 16;
  localparam logic [15:0] MBWD_MAX_REGS_W = 16'h0010;
  localparam logic [2:0] MBWD_HDR_LAST = 3'h3;
  localparam logic [2:0] MBWD_LEN_ERR = 3'h2;
  localparam logic [2:0] MBWD_LEN_OK = 3'h5;

  typedef enum logic [3:0] {
    MBWD_ST_FUNC,
    MBWD_ST_HDR,
    MBWD_ST_BCNT,
    MBWD_ST_DATA,
    MBWD_ST_DRAIN,
    MBWD_ST_EVAL,
    MBWD_ST_CHECK,
    MBWD_ST_WRITE,
    MBWD_ST_RESP,
    MBWD_ST_WAIT
  } mbwd_state_t;

endpackage : mbwd_pkg

// file: mbwd_tx.sv
// Response byte sender: holds up to five PDU bytes and hands them out one at a time.
// Assumes the caller loads only while busy is low.
`timescale 1ns/10ps
module mbwd_tx (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [39:0] bytes,
  input wire logic [2:0] len,
  output logic busy,
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  output logic rsp_last,
  input wire logic rsp_ready
);
  import mbwd_pkg::*;

  logic [39:0] sh_q;
  logic [2:0] left_q;

  // Bytes leave high-order first, so every two-byte field goes out high byte then low byte.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sh_q <= 40'h0;
      left_q <= 3'h0;
    end else if (load) begin
      sh_q <= bytes;
      left_q <= len;
    end else if (rsp_valid && rsp_ready) begin
      sh_q <= {sh_q[31:0], 8'h00};
      left_q <= left_q - 3'h1;
    end
  end

  assign busy = (left_q != 3'h0);
  assign rsp_valid = busy;
  assign rsp_byte = sh_q[39:32];
  assign rsp_last = (left_q == 3'h1);

endmodule : mbwd_tx

// file: mbwd_handler.sv
// Modbus slave handler for single and multiple register writes and line diagnosis.
// Assumes a framing layer that delivers request PDU bytes with a last flag and takes the response the same way.
// Functional notes
// - A 0x42 request writes one to sixteen consecutive registers to working memory only.
// - A good 0x42 request is answered with function, start address and register count only.
// - A write to a parameter that may not change while the drive runs is refused with exception 1.
// - A diagnosis request carries a two-byte sub-function and two data bytes and is answered per sub-function.
// - Sub-function zero echoes function, sub-function and data exactly as received.
// - Diagnosis neither reads nor writes any parameter register.
// - A diagnosis sub-function lets the master clear the communication error counters.
// - A 0x06 request stores its value in the nonvolatile register at its address.
// - A single write is answered only after the register is updated, echoing function, address and value.
// - A 0x41 request behaves as 0x06 but updates working memory only.
// - A volatile write takes effect at once and the stored value returns after a power cycle.
// - Every failed request is answered with function plus 0x80 and a one-byte exception code.
// - Two-byte fields travel high byte first.
`timescale 1ns/10ps
module mbwd_handler (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [7:0] req_byte,
  input wire logic req_last,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  output logic rsp_last,
  input wire logic rsp_ready,
  input wire logic drive_running,
  output logic [15:0] chk_addr,
  input wire logic chk_locked,
  output logic wr_en,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data,
  output logic wr_volatile,
  input wire logic wr_ack,
  output logic cnt_clr
);
  import mbwd_pkg::*;

  mbwd_state_t state_q;
  logic [7:0] func_q;
  logic [15:0] f1_q;
  logic [15:0] f2_q;
  logic [7:0] bcnt_q;
  logic [2:0] hcnt_q;
  logic [5:0] dcnt_q;
  logic [7:0] err_q;
  logic [3:0] idx_q;
  logic [15:0] addr_q;
  logic [7:0] hi_q;
  logic [15:0] buf_q [0:MBWD_MAX_REGS-1];
  logic clr_q;
  logic tx_load;
  logic tx_busy;
  logic take;
  logic is_multi;
  logic is_single;
  logic last_idx;
  logic [7:0] err_len;

  assign req_ready = (state_q == MBWD_ST_FUNC) || (state_q == MBWD_ST_HDR) || (state_q == MBWD_ST_BCNT) ||
                     (state_q == MBWD_ST_DATA) || (state_q == MBWD_ST_DRAIN);
  assign take = req_valid && req_ready;
  assign is_multi = (func_q == MBWD_FC_WRM_RAM);
  assign is_single = (func_q == MBWD_FC_WR_SAVE) || (func_q == MBWD_FC_WR_RAM);
  assign last_idx = is_multi ? ({12'h000, idx_q} == f2_q - 16'h0001) : 1'b1;
  // A framing fault keeps whatever exception was already decided.
  assign err_len = (err_q == MBWD_EXC_NONE) ? MBWD_EXC_ILL_VALUE : err_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Request parsing and sequencing.

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= MBWD_ST_FUNC;
      func_q <= 8'h00;
      f1_q <= 16'h0000;
      f2_q <= 16'h0000;
      bcnt_q <= 8'h00;
      hcnt_q <= 3'h0;
      dcnt_q <= 6'h00;
      err_q <= MBWD_EXC_NONE;
      idx_q <= 4'h0;
      addr_q <= 16'h0000;
    end else begin
      case (state_q)
        MBWD_ST_FUNC: begin
          if (take) begin
            func_q <= req_byte;
            hcnt_q <= 3'h0;
            idx_q <= 4'h0;
            if (req_byte == MBWD_FC_DIAG || req_byte == MBWD_FC_WR_SAVE || req_byte == MBWD_FC_WR_RAM ||
                req_byte == MBWD_FC_WRM_RAM) begin
              err_q <= MBWD_EXC_NONE;
              state_q <= req_last ? MBWD_ST_EVAL : MBWD_ST_HDR;
              if (req_last) begin
                err_q <= MBWD_EXC_ILL_VALUE;
              end
            end else begin
              err_q <= MBWD_EXC_ILL_FUNC;
              state_q <= req_last ? MBWD_ST_EVAL : MBWD_ST_DRAIN;
            end
          end
        end
        MBWD_ST_HDR: begin
          if (take) begin
            {f1_q, f2_q} <= {f1_q[7:0], f2_q, req_byte};
            hcnt_q <= hcnt_q + 3'h1;
            if (hcnt_q != MBWD_HDR_LAST) begin
              if (req_last) begin
                err_q <= err_len;
                state_q <= MBWD_ST_EVAL;
              end
            end else if (req_last) begin
              if (is_multi) begin
                err_q <= err_len;
              end
              state_q <= MBWD_ST_EVAL;
            end else if (is_multi) begin
              state_q <= MBWD_ST_BCNT;
            end else begin
              err_q <= err_len;
              state_q <= MBWD_ST_DRAIN;
            end
          end
        end
        MBWD_ST_BCNT: begin
          if (take) begin
            bcnt_q <= req_byte;
            dcnt_q <= 6'h00;
            if (req_last) begin
              err_q <= err_len;
              state_q <= MBWD_ST_EVAL;
            end else begin
              state_q <= MBWD_ST_DATA;
            end
          end
        end
        MBWD_ST_DATA: begin
          if (take) begin
            if (dcnt_q != 6'h3f) begin
              dcnt_q <= dcnt_q + 6'h01;
            end
            if (req_last) begin
              if ({2'b00, dcnt_q} + 8'h01 != bcnt_q) begin
                err_q <= err_len;
              end
              state_q <= MBWD_ST_EVAL;
            end
          end
        end
        MBWD_ST_DRAIN: begin
          if (take && req_last) begin
            state_q <= MBWD_ST_EVAL;
          end
        end
        MBWD_ST_EVAL: begin
          addr_q <= f1_q;
          idx_q <= 4'h0;
          if (err_q != MBWD_EXC_NONE) begin
            state_q <= MBWD_ST_RESP;
          end else if (is_multi && (f2_q == 16'h0000 || f2_q > MBWD_MAX_REGS_W ||
                                    {8'h00, bcnt_q} != {f2_q[14:0], 1'b0})) begin
            err_q <= MBWD_EXC_ILL_VALUE;
            state_q <= MBWD_ST_RESP;
          end else if (func_q == MBWD_FC_DIAG) begin
            if (f1_q != MBWD_SUB_ECHO && f1_q != MBWD_SUB_CLR_CNT) begin
              err_q <= MBWD_EXC_ILL_FUNC;
            end
            state_q <= MBWD_ST_RESP;
          end else begin
            state_q <= MBWD_ST_CHECK;
          end
        end
        // Every target is checked before any is written, so a refused block leaves memory untouched.
        MBWD_ST_CHECK: begin
          if (drive_running && chk_locked) begin
            err_q <= MBWD_EXC_ILL_FUNC;
            state_q <= MBWD_ST_RESP;
          end else if (last_idx) begin
            idx_q <= 4'h0;
            addr_q <= f1_q;
            state_q <= MBWD_ST_WRITE;
          end else begin
            idx_q <= idx_q + 4'h1;
            addr_q <= addr_q + 16'h0001;
          end
        end
        MBWD_ST_WRITE: begin
          if (wr_ack) begin
            if (last_idx) begin
              state_q <= MBWD_ST_RESP;
            end else begin
              idx_q <= idx_q + 4'h1;
              addr_q <= addr_q + 16'h0001;
            end
          end
        end
        MBWD_ST_RESP: begin
          state_q <= MBWD_ST_WAIT;
        end
        MBWD_ST_WAIT: begin
          if (!tx_busy) begin
            state_q <= MBWD_ST_FUNC;
          end
        end
        default: begin
          state_q <= MBWD_ST_FUNC;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Value buffer; a single write keeps its value in the first slot.

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hi_q <= 8'h00;
    end else if (state_q == MBWD_ST_DATA && take) begin
      if (!dcnt_q[0]) begin
        hi_q <= req_byte;
      end else if (!dcnt_q[5]) begin
        buf_q[dcnt_q[4:1]] <= {hi_q, req_byte};
      end
    end else if (state_q == MBWD_ST_EVAL && is_single) begin
      buf_q[0] <= f2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register store port and counter clear.

  assign chk_addr = addr_q;
  assign wr_en = (state_q == MBWD_ST_WRITE);
  assign wr_addr = addr_q;
  assign wr_data = buf_q[idx_q];
  // Only 0x06 reaches the saved copy; the others change working memory and act at once.
  assign wr_volatile = (func_q != MBWD_FC_WR_SAVE);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clr_q <= 1'b0;
    end else begin
      clr_q <= state_q == MBWD_ST_RESP && err_q == MBWD_EXC_NONE && func_q == MBWD_FC_DIAG &&
               f1_q == MBWD_SUB_CLR_CNT;
    end
  end
  assign cnt_clr = clr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Response assembly.

  assign tx_load = (state_q == MBWD_ST_RESP);

  mbwd_tx u_tx (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(tx_load),
    .bytes((err_q != MBWD_EXC_NONE) ? {func_q | MBWD_EXC_FLAG, err_q, 24'h000000} :
           {func_q, f1_q, f2_q}),
    .len((err_q != MBWD_EXC_NONE) ? MBWD_LEN_ERR : MBWD_LEN_OK),
    .busy(tx_busy),
    .rsp_valid(rsp_valid),
    .rsp_byte(rsp_byte),
    .rsp_last(rsp_last),
    .rsp_ready(rsp_ready)
  );

endmodule : mbwd_handler

// file: mbwd_handler_monitor.sv
// Port checker of the write and diagnosis handler.
// Assumes a bind to mbwd_handler and sees its ports only.
`timescale 1ns/10ps
module mbwd_handler_monitor
  import mbwd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [7:0] req_byte,
  input wire logic req_last,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_last,
  input wire logic rsp_ready,
  input wire logic wr_en,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_volatile,
  input wire logic wr_ack,
  input wire logic cnt_clr
);
  logic sop_q;
  logic [7:0] fc_q;
  logic [2:0] rc_q;
  // The first request byte and the response byte count let the checks tie answers to requests.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sop_q <= 1'b1;
      rc_q <= 3'h0;
    end else begin
      if (req_valid && req_ready) sop_q <= req_last;
      if (req_valid && req_ready && sop_q) fc_q <= req_byte;
      if (rsp_valid && rsp_ready) rc_q <= rsp_last ? 3'h0 : rc_q + 3'h1;
    end
  end
  ////////////////////////////////////////
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr_wait; wr_en && !wr_ack; endsequence
  sequence s_wr_held; wr_en && $stable(wr_addr) && $stable(wr_data); endsequence
  sequence s_rsp_end; rsp_valid && rsp_ready && rsp_last; endsequence
  a_wr_hold: assert property (s_wr_wait |=> s_wr_held) else $error("write dropped");
  a_wr_quiet: assert property (wr_en |-> !req_ready && !rsp_valid) else $error("write overlaps");
  a_wr_kind: assert property (wr_en |-> wr_volatile == (fc_q != MBWD_FC_WR_SAVE)) else $error("memory kind");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte))
    else $error("byte moved");
  a_rsp_func: assert property (rsp_valid && rc_q == 3'h0 |-> rsp_byte[6:0] == fc_q[6:0])
    else $error("function");
  a_rsp_len: assert property (rsp_valid && rsp_last |-> rc_q == 3'h1 || rc_q == 3'h4) else $error("length");
  a_req_back: assert property (s_rsp_end |-> ##[1:3] req_ready) else $error("request side stuck");
  a_clr_pulse: assert property (cnt_clr |=> !cnt_clr && !wr_en) else $error("clear pulse");
endmodule : mbwd_handler_monitor

// file: mbwd_master.sv
// Master station model: sends one request PDU, then gathers the whole answer.
// Assumes each call starts at a rising clock edge.
`timescale 1ns/10ps
module mbwd_master (
  input wire logic sys_clk,
  output logic req_valid = 1'b0,
  output logic [7:0] req_byte = 8'h00,
  output logic req_last = 1'b0,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_last,
  output logic rsp_ready = 1'b0
);
  task automatic xfer(input logic [7:0] q[$], input logic slow, output logic [7:0] r[$]);
    logic done;
    r = {};
    foreach (q[i]) begin
      req_valid <= 1'b1;
      req_byte <= q[i];
      req_last <= i == q.size() - 1;
      do @(posedge sys_clk); while (!req_ready);
    end
    // A released lane shows the inverse, so a late sample cannot pass.
    req_valid <= 1'b0;
    req_last <= 1'b0;
    req_byte <= ~q[q.size() - 1];
    done = 1'b0;
    while (!done) begin
      @(posedge sys_clk);
      done = rsp_valid && rsp_ready && rsp_last;
      if (rsp_valid && rsp_ready) r.push_back(rsp_byte);
      rsp_ready <= slow ? ~rsp_ready : 1'b1;
    end
  endtask : xfer
endmodule : mbwd_master

// file: mbwd_handler_tb.sv
// Self-checking bench of the write and diagnosis handler.
// Assumes the master model on the request side; the bench answers the register port.
`timescale 1ns/10ps
module mbwd_handler_tb;
  import mbwd_pkg::*;
  typedef logic [7:0] mbwd_bq_t[$];
  typedef logic [32:0] mbwd_wq_t[$];
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic drive_running = 1'b0;
  logic wr_ack = 1'b0;
  logic tick_q = 1'b0;
  logic req_valid, req_last, req_ready, rsp_valid, rsp_last, rsp_ready, chk_locked, wr_en, wr_volatile, cnt_clr;
  logic [7:0] req_byte, rsp_byte;
  logic [15:0] chk_addr, wr_addr, wr_data;
  logic [15:0] lock_addr = 16'hffff;
  logic [31:0] st = 32'hca640830;
  int bad_count = 0;
  int samples_checked = 0;
  int clr_seen = 0;
  int clr_exp = 0;
  mbwd_wq_t wq;
  always #2 sys_clk = ~sys_clk;
  assign chk_locked = chk_addr == lock_addr;
  mbwd_handler u_dut (.sys_clk, .rst, .req_valid, .req_byte, .req_last, .req_ready, .rsp_valid, .rsp_byte,
    .rsp_last, .rsp_ready, .drive_running, .chk_addr, .chk_locked, .wr_en, .wr_addr, .wr_data, .wr_volatile,
    .wr_ack, .cnt_clr);
  mbwd_master u_mst (.sys_clk, .req_valid, .req_byte, .req_last, .req_ready, .rsp_valid, .rsp_byte, .rsp_last,
    .rsp_ready);
  // Acks come after one or two cycles, so the held strobe is exercised.
  always @(posedge sys_clk) begin
    tick_q <= ~tick_q;
    wr_ack <= wr_en && !wr_ack && tick_q;
    if (!rst && wr_en && wr_ack) wq.push_back({wr_volatile, wr_addr, wr_data});
    if (!rst && cnt_clr) clr_seen++;
  end
  ////////////////////////////////////////
  function logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction : rnd
  task automatic cmp(string nm, logic [32:0] e, logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  function automatic mbwd_bq_t mk5(logic [7:0] f, logic [15:0] a, logic [15:0] b);
    mbwd_bq_t q;
    q = {f, a[15:8], a[7:0], b[15:8], b[7:0]};
    return q;
  endfunction : mk5
  function automatic mbwd_bq_t mkm(logic [15:0] a, logic [15:0] n, logic [7:0] bc);
    mbwd_bq_t q;
    q = {MBWD_FC_WRM_RAM, a[15:8], a[7:0], n[15:8], n[7:0], bc};
    repeat (2 * n) q.push_back(8'(rnd()));
    return q;
  endfunction : mkm
  function automatic void model(mbwd_bq_t q, logic run, logic [15:0] lk, output mbwd_bq_t r, output mbwd_wq_t w);
    logic [15:0] a;
    logic [15:0] b;
    logic [7:0] ex;
    a = {q[1], q[2]};
    b = {q[3], q[4]};
    ex = MBWD_EXC_NONE;
    w = {};
    if (q[0] == MBWD_FC_WRM_RAM) begin
      if (b == 0 || b > MBWD_MAX_REGS_W || q[5] != 8'(2 * b) || q.size() != 6 + 2 * b) ex = MBWD_EXC_ILL_VALUE;
      else for (int i = 0; i < b; i++) w.push_back({1'b1, a + 16'(i), q[6 + 2 * i], q[7 + 2 * i]});
    end else if (q[0] == MBWD_FC_WR_SAVE || q[0] == MBWD_FC_WR_RAM) begin
      w.push_back({q[0] == MBWD_FC_WR_RAM, a, b});
    end else if (q[0] != MBWD_FC_DIAG || (a != MBWD_SUB_ECHO && a != MBWD_SUB_CLR_CNT)) begin
      ex = MBWD_EXC_ILL_FUNC;
    end
    foreach (w[i]) if (run && w[i][31:16] == lk) ex = MBWD_EXC_ILL_FUNC;
    if (ex != MBWD_EXC_NONE) begin
      r = {q[0] | MBWD_EXC_FLAG, ex};
      w = {};
    end else r = {q[0], q[1], q[2], q[3], q[4]};
  endfunction : model
  task automatic check(mbwd_bq_t q, logic run, logic [15:0] lk);
    mbwd_bq_t er, gr;
    mbwd_wq_t ew;
    model(q, run, lk, er, ew);
    if (q[0] == MBWD_FC_DIAG && {q[1], q[2]} == MBWD_SUB_CLR_CNT) clr_exp++;
    drive_running <= run;
    lock_addr <= lk;
    wq = {};
    u_mst.xfer(q, st[3], gr);
    cmp("rsp_len", 33'(er.size()), 33'(gr.size()));
    foreach (er[i]) cmp("rsp_byte", 33'(er[i]), 33'(gr[i]));
    cmp("wr_count", 33'(ew.size()), 33'(wq.size()));
    foreach (ew[i]) cmp("wr_entry", ew[i], wq[i]);
  endtask : check
  initial begin
    mbwd_bq_t q;
    logic [31:0] r;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    q = {8'h42, 8'h00, 8'h0e, 8'h00, 8'h02, 8'h04, 8'h01, 8'hf4, 8'h02, 8'h58};
    check(q, 1'b1, 16'hffff);
    check(mkm(16'h7ff0, 16'h0010, 8'h20), 1'b1, 16'h0000);
    check(mkm(16'h0100, 16'h0000, 8'h00), 1'b0, 16'hffff);
    check(mkm(16'h0100, 16'h0011, 8'h22), 1'b0, 16'hffff);
    check(mkm(16'h0100, 16'h0002, 8'h05), 1'b0, 16'hffff);
    check(mkm(16'h0100, 16'h0004, 8'h08), 1'b1, 16'h0103);
    check(mk5(MBWD_FC_WR_SAVE, 16'h1234, 16'h5678), 1'b1, 16'h1234);
    check(mk5(MBWD_FC_WR_RAM, 16'h1234, 16'h5678), 1'b0, 16'h1234);
    check(mk5(MBWD_FC_DIAG, 16'h0001, 16'ha537), 1'b0, 16'hffff);
    check(mk5(MBWD_FC_DIAG, MBWD_SUB_CLR_CNT, 16'h00ff), 1'b0, 16'hffff);
    repeat (2) check(mk5(MBWD_FC_WR_RAM, 16'h0021, 16'(rnd())), 1'b1, 16'hffff);
    check(mk5(8'h03, 16'h0000, 16'h0001), 1'b0, 16'hffff);
    for (int k = 0; k < 40; k++) begin
      r = rnd();
      if (k % 4 == 3) q = mkm(r[15:0], 16'(r[19:16]) + 16'h0001, {3'h0, r[19:16], 1'b0} + 8'h02);
      else if (k % 4 == 2) q = mk5(MBWD_FC_DIAG, r[0] ? MBWD_SUB_ECHO : {12'h000, r[4:1]}, r[31:16]);
      else q = mk5(k % 4 == 1 ? MBWD_FC_WR_RAM : MBWD_FC_WR_SAVE, r[15:0], r[31:16]);
      check(q, r[21], r[20] ? r[15:0] : ~r[15:0]);
    end
    cmp("clr_count", 33'(clr_exp), 33'(clr_seen));
    close_out();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end
  task automatic close_out();
    $display("Checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
endmodule : mbwd_handler_tb
bind mbwd_handler mbwd_handler_monitor u_mon (.sys_clk, .rst, .req_valid, .req_byte, .req_last, .req_ready,
  .rsp_valid, .rsp_byte, .rsp_last, .rsp_ready, .wr_en, .wr_addr, .wr_data, .wr_volatile, .wr_ack, .cnt_clr);
